// *** qdac_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module qdac_host (
    output logic link_sclk,
    output logic select_load_n,
    output logic serial_in
);
    initial begin
        link_sclk = 1'b0;
        select_load_n = 1'b1;
        serial_in = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Clock pulses with select high; data line keeps changing
    task automatic idle(input int n);
        repeat (n) begin
            #15 link_sclk = 1'b1;
            #15 link_sclk = 1'b0;
            serial_in = ~serial_in;
        end
    endtask
    // One frame; the clock stands still outside it
    task automatic send(input logic [63:0] w, input int nb);
        #3 select_load_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            #8 serial_in = w[i];
            #7 link_sclk = 1'b1;
            #15 link_sclk = 1'b0;
        end
        #8 select_load_n = 1'b1;
        serial_in = ~serial_in;
        // Gap so the select high level is seen before any next frame
        #150;
    endtask
endmodule
`default_nettype wire

// *** qdac_pkg.sv ***
`include "qdac_regs.svh"

package qdac_pkg;

    typedef enum logic [3:0] {
        QDAC_CMD_WRITE = 4'h0,
        QDAC_CMD_UPDATE = 4'h1,
        QDAC_CMD_WRITE_UPDATE_ALL = 4'h2,
        QDAC_CMD_WRITE_UPDATE = 4'h3,
        QDAC_CMD_POWER_DOWN = 4'h4,
        QDAC_CMD_NOP = 4'hF
    } qdac_cmd_e;

    typedef enum logic [1:0] {
        QDAC_ST_IDLE = 2'h0,
        QDAC_ST_FRAME = 2'h1,
        QDAC_ST_EXEC = 2'h3
    } qdac_state_e;

    typedef struct packed {
        logic [3:0] command_field;
        logic [3:0] channel_address_field;
        logic [`QDAC_DATA_BITS-1:0] data;
    } qdac_word_s;

    typedef struct packed {
        logic [`QDAC_DATA_BITS-1:0] code;
        logic active;
        logic settling;
    } qdac_chan_s;

endpackage

// *** qdac_regs.svh ***
`ifndef QDAC_REGS_SVH
`define QDAC_REGS_SVH

// Shift register and command word layout
`define QDAC_SHIFT_BITS 32
`define QDAC_CMD_MSB 23
`define QDAC_CMD_LSB 20
`define QDAC_ADDR_MSB 19
`define QDAC_ADDR_LSB 16
`define QDAC_DATA_MSB 15
`define QDAC_DATA_LSB 0
`define QDAC_DATA_BITS 16
`define QDAC_CHANNELS 4
`define QDAC_ADDR_ALL 4'hF

// Reset values
`define QDAC_SHIFT_RST 32'h0000_0000
`define QDAC_INREG_RST 16'h0000
`define QDAC_DACREG_RST 16'h0000
`define QDAC_PDOWN_RST 1'b0
`define QDAC_SDO_RST 1'b0

// Timing
`define QDAC_SYS_KHZ 40000
`define QDAC_PWRUP_NS 5000
`define QDAC_PWRUP_ALL_NS 12000
`define QDAC_PWRUP_CYC ((`QDAC_PWRUP_NS * `QDAC_SYS_KHZ + 999999) / 1000000)
`define QDAC_PWRUP_ALL_CYC ((`QDAC_PWRUP_ALL_NS * `QDAC_SYS_KHZ + 999999) / 1000000)
`define QDAC_CNT_BITS 9

`endif

// *** qdac_shifter.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "qdac_regs.svh"

module qdac_shifter (
    input wire logic link_sclk,
    input wire logic rst_b,
    input wire logic select_load_n,
    input wire logic serial_in,
    output logic [`QDAC_SHIFT_BITS-1:0] shift_word,
    output logic serial_out
);
    import qdac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset brought onto the link clock; it only takes hold while the clock runs
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge link_sclk) begin
        rst_meta_q <= rst_b;
        rst_sync_q <= rst_meta_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift register
    logic [`QDAC_SHIFT_BITS-1:0] shift_q;
    logic [`QDAC_SHIFT_BITS-1:0] shift_d;

    always_comb begin
        shift_d = shift_q;
        if (!rst_sync_q) begin
            shift_d = `QDAC_SHIFT_RST;
        end else if (!select_load_n) begin
            shift_d = {shift_q[`QDAC_SHIFT_BITS-2:0], serial_in};
        end
    end

    always_ff @(posedge link_sclk) begin
        shift_q <= shift_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chain output changes on the falling edge so the next device gets a half period of setup
    logic sdo_q;
    logic sdo_d;

    always_comb begin
        sdo_d = rst_sync_q ? shift_q[`QDAC_SHIFT_BITS-1] : `QDAC_SDO_RST;
    end

    always_ff @(negedge link_sclk) begin
        sdo_q <= sdo_d;
    end

    assign shift_word = shift_q;
    assign serial_out = sdo_q;

endmodule
`default_nettype wire

// *** qdac_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "qdac_regs.svh"

module qdac_top #(
    parameter int CODE_BITS = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic link_sclk,
    input wire logic select_load_n,
    input wire logic serial_in,
    input wire logic async_clear_n,
    output logic serial_out,
    output qdac_pkg::qdac_chan_s [`QDAC_CHANNELS-1:0] chan_out
);
    import qdac_pkg::*;

    localparam int NCH = `QDAC_CHANNELS;
    localparam int DROP_BITS = `QDAC_DATA_BITS - CODE_BITS;
    localparam logic [`QDAC_DATA_BITS-1:0] CODE_MASK = 16'(16'hFFFF << DROP_BITS);
    localparam logic [`QDAC_CNT_BITS-1:0] PWRUP_CYC = `QDAC_CNT_BITS'(`QDAC_PWRUP_CYC);
    localparam logic [`QDAC_CNT_BITS-1:0] PWRUP_ALL_CYC = `QDAC_CNT_BITS'(`QDAC_PWRUP_ALL_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: shift register and chain output
    logic [`QDAC_SHIFT_BITS-1:0] shift_word;

    qdac_shifter u_shifter (
        .link_sclk(link_sclk),
        .rst_b(rst_b),
        .select_load_n(select_load_n),
        .serial_in(serial_in),
        .shift_word(shift_word),
        .serial_out(serial_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for select and clear; first stage feeds only the second
    logic sel_meta_q;
    logic sel_sync_q;
    logic clr_meta_q;
    logic clr_sync_q;
    logic sel_meta_d;
    logic sel_sync_d;
    logic clr_meta_d;
    logic clr_sync_d;

    always_comb begin
        sel_meta_d = sel_meta_q;
        sel_sync_d = sel_sync_q;
        clr_meta_d = clr_meta_q;
        clr_sync_d = clr_sync_q;
        if (!rst_b) begin
            sel_meta_d = 1'b1;
            sel_sync_d = 1'b1;
            clr_meta_d = 1'b1;
            clr_sync_d = 1'b1;
        end else if (clk_en) begin
            sel_meta_d = select_load_n;
            sel_sync_d = sel_meta_q;
            clr_meta_d = async_clear_n;
            clr_sync_d = clr_meta_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        sel_meta_q <= sel_meta_d;
        sel_sync_q <= sel_sync_d;
        clr_meta_q <= clr_meta_d;
        clr_sync_q <= clr_sync_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame tracking; the shift word is taken only after select is seen high,
    // when the link clock no longer shifts it, so all bits are stable together.
    // A select high pulse shorter than about three system clocks may be missed.
    qdac_state_e state_q;
    qdac_state_e state_d;
    qdac_word_s word_q;
    qdac_word_s word_d;

    always_comb begin
        state_d = state_q;
        word_d = word_q;
        if (!rst_b) begin
            state_d = QDAC_ST_IDLE;
            word_d = '{command_field: QDAC_CMD_NOP, channel_address_field: 4'h0, data: 16'h0000};
        end else if (clk_en) begin
            unique case (state_q)
                QDAC_ST_IDLE: begin
                    if (!sel_sync_q) begin
                        state_d = QDAC_ST_FRAME;
                    end
                end
                QDAC_ST_FRAME: begin
                    if (sel_sync_q) begin
                        state_d = QDAC_ST_EXEC;
                        word_d = shift_word[`QDAC_CMD_MSB:`QDAC_DATA_LSB];
                    end
                end
                QDAC_ST_EXEC: begin
                    state_d = QDAC_ST_IDLE;
                end
                default: begin
                    state_d = QDAC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        state_q <= state_d;
        word_q <= word_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode into per-channel strobes
    logic exec;
    logic [NCH-1:0] sel_vec;
    logic [NCH-1:0] wr_vec;
    logic [NCH-1:0] upd_vec;
    logic [NCH-1:0] pd_vec;
    logic upd_all;
    logic [NCH-1:0] pd_now;
    logic [`QDAC_DATA_BITS-1:0] wr_code;

    assign exec = (state_q == QDAC_ST_EXEC) && clk_en;
    assign wr_code = word_q.data & CODE_MASK;

    always_comb begin
        sel_vec = '0;
        wr_vec = '0;
        upd_vec = '0;
        pd_vec = '0;
        upd_all = 1'b0;
        if (word_q.channel_address_field == `QDAC_ADDR_ALL) begin
            sel_vec = '1;
        end else if (word_q.channel_address_field < 4'(NCH)) begin
            sel_vec[word_q.channel_address_field[1:0]] = 1'b1;
        end
        if (exec) begin
            unique case (word_q.command_field)
                QDAC_CMD_WRITE: begin
                    wr_vec = sel_vec;
                end
                QDAC_CMD_UPDATE: begin
                    upd_vec = sel_vec;
                end
                QDAC_CMD_WRITE_UPDATE_ALL: begin
                    wr_vec = sel_vec;
                    upd_vec = '1;
                    upd_all = 1'b1;
                end
                QDAC_CMD_WRITE_UPDATE: begin
                    wr_vec = sel_vec;
                    upd_vec = sel_vec;
                end
                QDAC_CMD_POWER_DOWN: begin
                    pd_vec = sel_vec;
                end
                default: begin
                    wr_vec = '0; // Reserved codes act as no operation
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel input, DAC, power and settling state
    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
        logic [`QDAC_DATA_BITS-1:0] inreg_q;
        logic [`QDAC_DATA_BITS-1:0] inreg_d;
        logic [`QDAC_DATA_BITS-1:0] dacreg_q;
        logic [`QDAC_DATA_BITS-1:0] dacreg_d;
        logic pd_q;
        logic pd_d;
        logic [`QDAC_CNT_BITS-1:0] cnt_q;
        logic [`QDAC_CNT_BITS-1:0] cnt_d;
        logic settle_q;
        logic settle_d;

        assign pd_now[ch] = pd_q;

        always_comb begin
            inreg_d = inreg_q;
            dacreg_d = dacreg_q;
            pd_d = pd_q;
            cnt_d = cnt_q;
            if (!rst_b) begin
                inreg_d = `QDAC_INREG_RST;
                dacreg_d = `QDAC_DACREG_RST;
                pd_d = `QDAC_PDOWN_RST;
                cnt_d = '0;
            end else if (clk_en) begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end
                if (!clr_sync_q) begin
                    // Clear wins over a write or update to the registers in the same cycle; power state still follows the command
                    inreg_d = `QDAC_INREG_RST;
                    dacreg_d = `QDAC_DACREG_RST;
                end else begin
                    if (wr_vec[ch]) begin
                        inreg_d = wr_code;
                    end
                    if (upd_vec[ch]) begin
                        dacreg_d = wr_vec[ch] ? wr_code : inreg_q;
                    end
                end
                if (upd_vec[ch]) begin
                    pd_d = 1'b0;
                    if (pd_q) begin
                        cnt_d = (&pd_now) ? PWRUP_ALL_CYC : PWRUP_CYC;
                    end
                end else if (pd_vec[ch]) begin
                    pd_d = 1'b1; // Registers are left untouched
                end
            end
        end

        always_comb begin
            settle_d = (cnt_d != '0);
        end

        always_ff @(posedge sys_clk) begin
            inreg_q <= inreg_d;
            dacreg_q <= dacreg_d;
            pd_q <= pd_d;
            cnt_q <= cnt_d;
            settle_q <= settle_d;
        end

        assign chan_out[ch].code = dacreg_q;
        assign chan_out[ch].active = ~pd_q;
        assign chan_out[ch].settling = settle_q;
    end

endmodule
`default_nettype wire

// *** qdac_top_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "qdac_regs.svh"
module qdac_top_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic link_sclk,
    input wire logic select_load_n,
    input wire logic serial_in,
    input wire logic async_clear_n,
    input wire logic serial_out,
    input wire qdac_pkg::qdac_chan_s [`QDAC_CHANNELS-1:0] chan_out
);
    import qdac_pkg::*;
    logic [31:0] sh_q;
    always_ff @(posedge link_sclk) begin
        if (!rst_b) begin
            sh_q <= 32'h0;
        end else if (!select_load_n) begin
            sh_q <= {sh_q[30:0], serial_in};
        end
    end
    property p_chain;
        @(posedge link_sclk) disable iff (!rst_b) serial_out == sh_q[31];
    endproperty
    a_chain: assert property (p_chain) else $error("serial_out order");
    ////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [8:0] cnt_q;
        always_ff @(posedge sys_clk) begin
            if (!rst_b || !chan_out[i].settling) begin
                cnt_q <= 9'h000;
            end else if (clk_en) begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
        property p_sel_low;
            @(posedge sys_clk) disable iff (!rst_b)
            (!select_load_n && async_clear_n) [*6] |-> $stable(chan_out[i].code);
        endproperty
        a_sel_low: assert property (p_sel_low) else $error("code moved while selected");
        property p_rst;
            @(posedge sys_clk) disable iff (!rst_b) $rose(rst_b) |-> chan_out[i] == 18'h00002;
        endproperty
        a_rst: assert property (p_rst) else $error("reset state");
        property p_clr;
            @(posedge sys_clk) disable iff (!rst_b) (!async_clear_n) [*5] |-> chan_out[i].code == 16'h0000;
        endproperty
        a_clr: assert property (p_clr) else $error("clear");
        property p_pdown;
            @(posedge sys_clk) disable iff (!rst_b) $fell(chan_out[i].active) |-> $stable(chan_out[i].code);
        endproperty
        a_pdown: assert property (p_pdown) else $error("power-down moved code");
        property p_exec;
            @(posedge sys_clk) disable iff (!rst_b) $fell(chan_out[i].active) |-> select_load_n;
        endproperty
        a_exec: assert property (p_exec) else $error("power-down inside frame");
        property p_wake;
            @(posedge sys_clk) disable iff (!rst_b) $rose(chan_out[i].active) |-> chan_out[i].settling;
        endproperty
        a_wake: assert property (p_wake) else $error("wake without settling");
        property p_settle;
            @(posedge sys_clk) disable iff (!rst_b)
            $fell(chan_out[i].settling) |-> cnt_q == 9'h0C8 || cnt_q == 9'h1E0;
        endproperty
        a_settle: assert property (p_settle) else $error("settling length");
    end
endmodule
bind qdac_top qdac_top_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .link_sclk(link_sclk),
    .select_load_n(select_load_n), .serial_in(serial_in), .async_clear_n(async_clear_n),
    .serial_out(serial_out), .chan_out(chan_out));
`default_nettype wire

// *** quad_dac_serial_command_port_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "qdac_regs.svh"
module quad_dac_serial_command_port_tb_top;
    import qdac_pkg::*;
    // Narrow variant so the dropped low data bits are visible
    localparam int CB = 12;
    localparam logic [15:0] MSK = 16'hFFFF << (16 - CB);
    localparam logic [3:0] CMDS [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
    localparam logic [3:0] ADRS [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
    localparam logic [31:0] CRN [8] = '{32'h004F0000, 32'h0021ABCD, 32'h00400000, 32'h00101234,
        32'hA532FFFF, 32'h00031234, 32'h00F35555, 32'h00130000};
    logic sys_clk, rst_b, clk_en, async_clear_n, serial_out, link_sclk, select_load_n, serial_in;
    qdac_chan_s [3:0] chan_out;
    int n_fail, comparisons, nb;
    logic [15:0] in_m [4];
    logic [15:0] code_m [4];
    logic [3:0] act_m, set_m;
    logic [31:0] sr_m, w, down_q;
    ////////////////////////////////////////////////////////////////
    qdac_top #(.CODE_BITS(CB)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .link_sclk(link_sclk),
        .select_load_n(select_load_n), .serial_in(serial_in), .async_clear_n(async_clear_n),
        .serial_out(serial_out), .chan_out(chan_out));
    qdac_host host (.link_sclk(link_sclk), .select_load_n(select_load_n), .serial_in(serial_in));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Next device of a chain samples the chain output on the rising edge
    always @(posedge link_sclk) begin
        if (!select_load_n) begin
            down_q <= {down_q[30:0], serial_out};
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check_all;
        for (int i = 0; i < 4; i++) begin
            check("code", chan_out[i].code, code_m[i]);
            check("active", chan_out[i].active, act_m[i]);
            check("settling", chan_out[i].settling, set_m[i]);
        end
        check("serial_out", serial_out, sr_m[31]);
    endtask
    function automatic void apply(input logic [23:0] cw);
        logic [3:0] c;
        logic hit;
        c = cw[23:20];
        for (int i = 0; i < 4; i++) begin
            hit = cw[19:16] == 4'hF || cw[19:16] == i[3:0];
            if (hit && c inside {4'h0, 4'h2, 4'h3})
                in_m[i] = cw[15:0] & MSK;
            if (hit && c == 4'h4)
                act_m[i] = 1'b0;
            if (c == 4'h2 || (hit && c inside {4'h1, 4'h3})) begin
                code_m[i] = in_m[i];
                set_m[i] = !act_m[i];
                act_m[i] = 1'b1;
            end
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        comparisons = 0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        async_clear_n = 1'b1;
        in_m = '{default: 16'h0000};
        code_m = '{default: 16'h0000};
        act_m = 4'hF;
        set_m = 4'h0;
        sr_m = 32'h0;
        void'($urandom(32'hE6C2));
        // Link clock runs during reset so the link side clears too
        host.idle(4);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        host.idle(4);
        check_all;
        for (int k = 0; k < 48; k++) begin
            if (k < 8) begin
                w = CRN[k];
                nb = (w[31:24] != 8'h00) ? 32 : 24;
            end else begin
                w = $urandom();
                w[23:16] = {CMDS[$urandom_range(5)], ADRS[$urandom_range(4)]};
                nb = $urandom_range(1) ? 32 : 24;
            end
            if (k == 20) begin
                @(posedge sys_clk);
                async_clear_n <= 1'b0;
                repeat (6) @(posedge sys_clk);
                async_clear_n <= 1'b1;
                repeat (4) @(posedge sys_clk);
                in_m = '{default: 16'h0000};
                code_m = '{default: 16'h0000};
                check_all;
            end
            @(posedge sys_clk);
            host.send({32'h0000_0000, w}, nb);
            apply(w[23:0]);
            sr_m = (nb == 32) ? w : {sr_m[7:0], w[23:0]};
            // Clocks with select high must leave the shift register alone
            host.idle(2);
            repeat (10) @(posedge sys_clk);
            check_all;
            if (k == 30) begin
                // Frozen enable must hold every output and the settling count
                clk_en <= 1'b0;
                repeat (20) @(posedge sys_clk);
                check_all;
                clk_en <= 1'b1;
            end
            repeat (500) @(posedge sys_clk);
            set_m = 4'h0;
        end
        // Two-device chain: the far device's word goes first, one select period
        w = 32'h0032_1234;
        @(posedge sys_clk);
        host.send({32'h00F3_BEEF, w}, 64);
        apply(w[23:0]);
        sr_m = w;
        repeat (10) @(posedge sys_clk);
        check("chain", down_q, 32'h00F3_BEEF);
        check_all;
        results;
    end
    initial begin
        #1500000;
        n_fail++;
        results;
    end
endmodule
`default_nettype wire
